// ===== pwm_capture_update_int_regs.sv
// ahb-lite register group: capture values, update control, interrupt enables
`timescale 1ns/1ps

module pwm_capture_update_int_regs
    import pwm_capture_update_int_pkg::*;
#(
    parameter int TIMER_W = 32
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [ADDR_W-1:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    // capture inputs, already prescaled, from pins
    input wire logic [NUM_CH-1:0] i_capture_in,
    input wire logic [TIMER_W-1:0] i_timer_value,
    // event pulses from timers, operators and fault handlers
    input wire logic [2:0] i_timer_stop_event,
    input wire logic [2:0] i_zero_event,
    input wire logic [2:0] i_period_reached_event,
    input wire logic [2:0] i_compare_a_event,
    input wire logic [2:0] i_compare_b_event,
    input wire logic [2:0] i_cycle_trip,
    input wire logic [2:0] i_oneshot_trip,
    // fault input levels
    input wire logic [2:0] i_fault_input_event,
    // active register update controls
    output logic [2:0] o_oper_refresh_allow,
    output logic [2:0] o_oper_forced_refresh,
    output logic o_global_forced_refresh,
    output logic [NUM_CH-1:0] o_capture_event,
    output logic o_irq
);

    // the read path carries at most one 32-bit word
    if (TIMER_W < 1 || TIMER_W > 32) begin : g_bad_timer_w
        $error("TIMER_W must lie between 1 and 32");
    end

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta_b_q;
    logic rst_b_q;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_b_q <= 1'b0;
            rst_b_q <= 1'b0;
        end else begin
            rst_meta_b_q <= 1'b1;
            rst_b_q <= rst_meta_b_q;
        end
    end

    // ----------------------------------------------------------------
    // bus phase tracking
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_IDLE,
        PH_WRITE,
        PH_READ_WAIT,
        PH_READ_OUT
    } phase_t;

    phase_t phase_q;
    phase_t phase_d;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] addr_d;
    logic word_q;
    logic word_d;
    logic [31:0] hrdata_q;
    logic [31:0] hrdata_d;
    logic addr_phase;
    logic wr_now;
    logic clr_now;

    assign addr_phase = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ || i_htrans == HTRANS_SEQ);
    // reads take one wait so a write just before is visible
    assign o_hreadyout = (phase_q != PH_READ_WAIT);
    assign o_hresp = 1'b0;
    assign o_hrdata = hrdata_q;
    assign wr_now = (phase_q == PH_WRITE) && word_q;

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [UPD_WIDTH-1:0] upd_q;
    logic [UPD_WIDTH-1:0] upd_d;
    logic [UPD_WIDTH-1:0] upd_prev_q;
    logic [INT_WIDTH-1:0] int_en_q;
    logic [INT_WIDTH-1:0] int_en_d;
    logic [INT_WIDTH-1:0] int_raw_q;
    logic [INT_WIDTH-1:0] int_raw_d;
    logic [INT_WIDTH-1:0] int_events;
    logic [2*NUM_CH-1:0] edge_sel_q;
    logic [2*NUM_CH-1:0] edge_sel_d;
    logic [2:0] fault_prev_q;
    logic [2:0] forced_d;
    logic [2:0] forced_q;
    logic global_forced_d;
    logic global_forced_q;
    logic [NUM_CH-1:0] cap_hit;
    logic [NUM_CH-1:0] cap_event_q;
    logic [NUM_CH-1:0] cap_edge;
    logic [TIMER_W-1:0] cap_val [NUM_CH];

    // ----------------------------------------------------------------
    // capture channels
    // ----------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch++) begin : g_cap
            logic sync1_q;
            logic sync2_q;
            logic sync3_q;
            logic lvl_q;
            logic lvl_d;
            logic edge_q;
            logic edge_d;
            logic [TIMER_W-1:0] val_q;
            logic [TIMER_W-1:0] val_d;
            logic change;
            logic rise;
            logic fall;
            logic hit;

            // a change counts once two late stages agree, filtering one-cycle glitches
            always_comb begin
                change = (sync2_q == sync3_q) && (sync3_q != lvl_q);
                rise = change && sync3_q;
                fall = change && !sync3_q;
                hit = (rise && edge_sel_q[2*ch+SEL_RISE_BIT])
                      || (fall && edge_sel_q[2*ch+SEL_FALL_BIT]);
                lvl_d = change ? sync3_q : lvl_q;
                val_d = hit ? i_timer_value : val_q;
                edge_d = hit ? fall : edge_q;
            end

            always_ff @(posedge i_clk or negedge rst_b_q) begin
                if (!rst_b_q) begin
                    sync1_q <= 1'b0;
                    sync2_q <= 1'b0;
                    sync3_q <= 1'b0;
                    lvl_q <= 1'b0;
                    edge_q <= 1'b0;
                    val_q <= '0;
                end else begin
                    sync1_q <= i_capture_in[ch];
                    sync2_q <= sync1_q;
                    sync3_q <= sync2_q;
                    lvl_q <= lvl_d;
                    edge_q <= edge_d;
                    val_q <= val_d;
                end
            end

            assign cap_edge[ch] = edge_q;
            assign cap_val[ch] = val_q;
            assign cap_hit[ch] = hit;
        end
    endgenerate

    // ----------------------------------------------------------------
    // interrupt event collection
    // ----------------------------------------------------------------
    always_comb begin
        int_events = '0;
        int_events[INT_TIMER_STOP_LSB +: 3] = i_timer_stop_event;
        int_events[INT_ZERO_LSB +: 3] = i_zero_event;
        int_events[INT_PERIOD_LSB +: 3] = i_period_reached_event;
        int_events[INT_FAULT_BEGIN_LSB +: 3] = i_fault_input_event & ~fault_prev_q;
        int_events[INT_FAULT_END_LSB +: 3] = ~i_fault_input_event & fault_prev_q;
        int_events[INT_CMP_A_LSB +: 3] = i_compare_a_event;
        int_events[INT_CMP_B_LSB +: 3] = i_compare_b_event;
        int_events[INT_CYCLE_TRIP_LSB +: 3] = i_cycle_trip;
        int_events[INT_ONESHOT_LSB +: 3] = i_oneshot_trip;
        int_events[INT_CAPTURE_LSB +: 3] = cap_hit;
    end

    // ----------------------------------------------------------------
    // bus and register next state
    // ----------------------------------------------------------------
    assign clr_now = wr_now && (addr_q == OFF_INTERRUPT_CLEAR);

    always_comb begin
        phase_d = PH_IDLE;
        addr_d = addr_q;
        word_d = word_q;
        hrdata_d = hrdata_q;
        upd_d = upd_q;
        int_en_d = int_en_q;
        edge_sel_d = edge_sel_q;

        if (phase_q == PH_READ_WAIT) begin
            phase_d = PH_READ_OUT;
            unique case (addr_q)
                OFF_CAPTURE_VALUE_CH0: hrdata_d = 32'(cap_val[0]);
                OFF_CAPTURE_VALUE_CH1: hrdata_d = 32'(cap_val[1]);
                OFF_CAPTURE_VALUE_CH2: hrdata_d = 32'(cap_val[2]);
                OFF_CAPTURE_EDGE_STATUS: hrdata_d = 32'(cap_edge);
                OFF_ACTIVE_UPDATE_CONTROL: hrdata_d = 32'(upd_q);
                OFF_INTERRUPT_ENABLE: hrdata_d = 32'(int_en_q);
                OFF_INTERRUPT_RAW: hrdata_d = 32'(int_raw_q);
                OFF_INTERRUPT_MASKED: hrdata_d = 32'(int_raw_q & int_en_q);
                OFF_CAPTURE_EDGE_SELECT: hrdata_d = 32'(edge_sel_q);
                default: hrdata_d = 32'h00000000;
            endcase
        end else if (addr_phase) begin
            addr_d = i_haddr;
            word_d = (i_hsize == HSIZE_WORD);
            phase_d = i_hwrite ? PH_WRITE : PH_READ_WAIT;
        end

        if (wr_now) begin
            unique case (addr_q)
                OFF_ACTIVE_UPDATE_CONTROL: upd_d = i_hwdata[UPD_WIDTH-1:0];
                OFF_INTERRUPT_ENABLE: int_en_d = i_hwdata[INT_WIDTH-1:0];
                OFF_CAPTURE_EDGE_SELECT: edge_sel_d = i_hwdata[2*NUM_CH-1:0];
                default: upd_d = upd_q;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // raw flags and refresh control
    // ----------------------------------------------------------------
    always_comb begin
        // a flag set in the clearing cycle survives
        int_raw_d = (int_raw_q & ~(clr_now ? i_hwdata[INT_WIDTH-1:0] : '0)) | int_events;
        global_forced_d = upd_q[UPD_GLOBAL_FORCED_BIT] ^ upd_prev_q[UPD_GLOBAL_FORCED_BIT];
        for (int op = 0; op < 3; op++) begin
            forced_d[op] = global_forced_d
                           || (upd_q[UPD_OPER_LSB+UPD_OPER_STRIDE*op+1]
                               ^ upd_prev_q[UPD_OPER_LSB+UPD_OPER_STRIDE*op+1]);
        end
    end

    always_ff @(posedge i_clk or negedge rst_b_q) begin
        if (!rst_b_q) begin
            phase_q <= PH_IDLE;
            addr_q <= '0;
            word_q <= 1'b0;
            hrdata_q <= 32'h00000000;
            upd_q <= UPD_RESET;
            upd_prev_q <= UPD_RESET;
            int_en_q <= INT_ENABLE_RESET;
            int_raw_q <= '0;
            edge_sel_q <= EDGE_SELECT_RESET;
            fault_prev_q <= 3'h0;
            forced_q <= 3'h0;
            global_forced_q <= 1'b0;
            cap_event_q <= '0;
        end else begin
            phase_q <= phase_d;
            addr_q <= addr_d;
            word_q <= word_d;
            hrdata_q <= hrdata_d;
            upd_q <= upd_d;
            upd_prev_q <= upd_q;
            int_en_q <= int_en_d;
            int_raw_q <= int_raw_d;
            edge_sel_q <= edge_sel_d;
            fault_prev_q <= i_fault_input_event;
            forced_q <= forced_d;
            global_forced_q <= global_forced_d;
            cap_event_q <= cap_hit;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    genvar op;
    generate
        for (op = 0; op < 3; op++) begin : g_op
            assign o_oper_refresh_allow[op] = upd_q[UPD_OPER_LSB+UPD_OPER_STRIDE*op]
                                              && upd_q[UPD_GLOBAL_ENABLE_BIT];
        end
    endgenerate

    assign o_oper_forced_refresh = forced_q;
    assign o_global_forced_refresh = global_forced_q;
    assign o_capture_event = cap_event_q;
    assign o_irq = |(int_raw_q & int_en_q);

endmodule

// ===== pwm_capture_update_int_pkg.sv
// constants for the pwm capture, update and interrupt register group
package pwm_capture_update_int_pkg;

    localparam int ADDR_W = 12;
    localparam int NUM_CH = 3;

    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CAPTURE_VALUE_CH0 = 12'h0fc;
    localparam logic [ADDR_W-1:0] OFF_CAPTURE_VALUE_CH1 = 12'h100;
    localparam logic [ADDR_W-1:0] OFF_CAPTURE_VALUE_CH2 = 12'h104;
    localparam logic [ADDR_W-1:0] OFF_CAPTURE_EDGE_STATUS = 12'h108;
    localparam logic [ADDR_W-1:0] OFF_ACTIVE_UPDATE_CONTROL = 12'h10c;
    localparam logic [ADDR_W-1:0] OFF_INTERRUPT_ENABLE = 12'h110;
    localparam logic [ADDR_W-1:0] OFF_INTERRUPT_RAW = 12'h114;
    localparam logic [ADDR_W-1:0] OFF_INTERRUPT_MASKED = 12'h118;
    localparam logic [ADDR_W-1:0] OFF_INTERRUPT_CLEAR = 12'h11c;
    localparam logic [ADDR_W-1:0] OFF_CAPTURE_EDGE_SELECT = 12'h120;

    // ----------------------------------------------------------------
    // active update control fields
    // ----------------------------------------------------------------
    localparam int UPD_GLOBAL_ENABLE_BIT = 0;
    localparam int UPD_GLOBAL_FORCED_BIT = 1;
    localparam int UPD_OPER_LSB = 2;
    localparam int UPD_OPER_STRIDE = 2;
    localparam int UPD_WIDTH = 8;
    localparam logic [UPD_WIDTH-1:0] UPD_RESET = 8'h00;

    // ----------------------------------------------------------------
    // interrupt field positions, three bits each
    // ----------------------------------------------------------------
    localparam int INT_TIMER_STOP_LSB = 0;
    localparam int INT_ZERO_LSB = 3;
    localparam int INT_PERIOD_LSB = 6;
    localparam int INT_FAULT_BEGIN_LSB = 9;
    localparam int INT_FAULT_END_LSB = 12;
    localparam int INT_CMP_A_LSB = 15;
    localparam int INT_CMP_B_LSB = 18;
    localparam int INT_CYCLE_TRIP_LSB = 21;
    localparam int INT_ONESHOT_LSB = 24;
    localparam int INT_CAPTURE_LSB = 27;
    localparam int INT_WIDTH = 30;
    localparam logic [INT_WIDTH-1:0] INT_ENABLE_RESET = 30'h00000000;

    // ----------------------------------------------------------------
    // capture edge select, two bits per channel
    // ----------------------------------------------------------------
    localparam int SEL_FALL_BIT = 0;
    localparam int SEL_RISE_BIT = 1;
    localparam logic [2*NUM_CH-1:0] EDGE_SELECT_RESET = 6'h00;

    // ahb encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage

// ===== pwm_regs_checker_assertions.sv
// concurrent checks on the capture, update and interrupt register ports
`timescale 1ns/1ps
module pwm_regs_checker
    import pwm_capture_update_int_pkg::*;
#(
    parameter int TIMER_W = 32
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_hsel,
    input wire logic [ADDR_W-1:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire logic o_hreadyout,
    input wire logic [NUM_CH-1:0] i_capture_in,
    input wire logic [2:0] o_oper_refresh_allow,
    input wire logic [2:0] o_oper_forced_refresh,
    input wire logic o_global_forced_refresh,
    input wire logic [NUM_CH-1:0] o_capture_event,
    input wire logic o_irq
);
    // ----------------------------------------
    // cycles since each cause, saturating
    // ----------------------------------------
    logic taken;
    logic [3:0] ctl_q, ctl_d, wr_q, wr_d, pin_q, pin_d;
    logic [NUM_CH-1:0] last_q;
    assign taken = i_hsel & i_hready & i_htrans[1];
    always_comb begin
        ctl_d = (ctl_q == 4'hf) ? ctl_q : ctl_q + 4'h1;
        wr_d = (wr_q == 4'hf) ? wr_q : wr_q + 4'h1;
        pin_d = (pin_q == 4'hf) ? pin_q : pin_q + 4'h1;
        if (taken && i_hwrite && i_haddr == OFF_ACTIVE_UPDATE_CONTROL) ctl_d = 4'h0;
        if (taken && i_hwrite) wr_d = 4'h0;
        if (i_capture_in != last_q) pin_d = 4'h0;
    end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctl_q <= 4'hf;
            wr_q <= 4'hf;
            pin_q <= 4'hf;
            last_q <= '0;
        end else begin
            ctl_q <= ctl_d;
            wr_q <= wr_d;
            pin_q <= pin_d;
            last_q <= i_capture_in;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);
    sequence read_taken;
        taken && !i_hwrite;
    endsequence
    sequence one_wait;
        !o_hreadyout ##1 o_hreadyout;
    endsequence
    read_wait_a: assert property (read_taken |=> one_wait)
        else $error("read did not answer after one wait");
    write_nowait_a: assert property (taken && i_hwrite |=> o_hreadyout)
        else $error("write data phase stalled");
    global_all_oper_a: assert property (o_global_forced_refresh |-> o_oper_forced_refresh == 3'h7)
        else $error("global forced refresh missed an operator");
    glob_after_write_a: assert property (o_global_forced_refresh |-> ctl_q <= 4'h4)
        else $error("global forced refresh without control write");
    oper_after_write_a: assert property (|o_oper_forced_refresh |-> ctl_q <= 4'h4)
        else $error("operator forced refresh without control write");
    allow_after_write_a: assert property (!$stable(o_oper_refresh_allow) |-> ctl_q <= 4'h2)
        else $error("refresh allow moved without control write");
    capture_after_pin_a: assert property (|o_capture_event |-> pin_q <= 4'h8)
        else $error("capture event without recent pin edge");
    irq_fall_write_a: assert property ($fell(o_irq) |-> wr_q <= 4'h3)
        else $error("interrupt dropped without a register write");
endmodule

// ===== testbench.sv
// self-checking bench for the capture, update and interrupt register group
`timescale 1ns/1ps
module testbench;
    import pwm_capture_update_int_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_hsel = 1'b0;
    logic i_hwrite = 1'b0;
    logic [ADDR_W-1:0] i_haddr = 12'h000;
    logic [1:0] i_htrans = 2'h0;
    logic [2:0] i_hsize = HSIZE_WORD;
    logic [31:0] i_hwdata = 32'h0;
    logic [31:0] i_timer_value = 32'h0;
    logic [2:0] i_capture_in = 3'h0;
    logic [2:0] i_fault_input_event = 3'h0;
    logic [2:0] ev [7] = '{default: 3'h0};
    logic [31:0] o_hrdata, rd, tv;
    logic o_hreadyout, o_hresp, o_global_forced_refresh, o_irq;
    logic [2:0] o_oper_refresh_allow, o_oper_forced_refresh, o_capture_event;
    logic [31:0] upd [4] = '{32'h1d, 32'h15, 32'h35, 32'h37};
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int n_glob = 0;
    int n_op [3] = '{default: 0};
    int n_cap [3] = '{default: 0};
    int lsb [9] = '{INT_TIMER_STOP_LSB, INT_ZERO_LSB, INT_PERIOD_LSB, INT_CMP_A_LSB, INT_CMP_B_LSB,
        INT_CYCLE_TRIP_LSB, INT_ONESHOT_LSB, INT_FAULT_BEGIN_LSB, INT_FAULT_END_LSB};

    pwm_capture_update_int_regs #(.TIMER_W(32)) dut (
        .i_clk, .i_rst_b, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hwdata,
        .i_hready(o_hreadyout), .o_hreadyout, .o_hresp, .o_hrdata, .i_capture_in, .i_timer_value,
        .i_timer_stop_event(ev[0]), .i_zero_event(ev[1]), .i_period_reached_event(ev[2]),
        .i_compare_a_event(ev[3]), .i_compare_b_event(ev[4]), .i_cycle_trip(ev[5]), .i_oneshot_trip(ev[6]),
        .i_fault_input_event, .o_oper_refresh_allow, .o_oper_forced_refresh, .o_global_forced_refresh,
        .o_capture_event, .o_irq);

    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // resyncs to a rising edge first, so callers may come from a negedge check
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_hsel <= 1'b1;
        i_htrans <= HTRANS_NONSEQ;
        i_haddr <= a;
        i_hwrite <= w;
        do @(posedge i_clk); while (o_hreadyout !== 1'b1);
        i_hsel <= 1'b0;
        i_htrans <= 2'h0;
        i_hwdata <= d;
        do @(posedge i_clk); while (o_hreadyout !== 1'b1);
        rd = o_hrdata;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rc(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(nm, exp, rd);
    endtask
    task automatic pin_chk(input string nm, input logic [31:0] exp);
        @(negedge i_clk);
        chk(nm, exp, {27'h0, o_hresp, o_irq, o_oper_refresh_allow});
    endtask
    task automatic end_of_test;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        forever #5 i_clk = ~i_clk;
    end
    // pulse counters and hang guard
    always @(posedge i_clk) begin
        cycles++;
        n_glob += o_global_forced_refresh;
        for (int k = 0; k < 3; k++) begin
            n_op[k] += o_oper_forced_refresh[k];
            n_cap[k] += o_capture_event[k];
        end
        if (cycles == 5000) begin
            errors++;
            end_of_test();
        end
    end

    initial begin
        repeat (4) @(posedge i_clk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_clk);
        // ----------------------------------------
        // reset values, unmapped place
        // ----------------------------------------
        rc("enable", OFF_INTERRUPT_ENABLE, 32'h0);
        rc("control", OFF_ACTIVE_UPDATE_CONTROL, 32'h0);
        i_hsize <= 3'h0;
        wr(OFF_INTERRUPT_ENABLE, 32'h1);
        i_hsize <= HSIZE_WORD;
        rc("byte write", OFF_INTERRUPT_ENABLE, 32'h0);
        wr(12'h200, 32'hffffffff);
        rc("unmapped", 12'h200, 32'h0);
        // ----------------------------------------
        // refresh control
        // ----------------------------------------
        wr(OFF_ACTIVE_UPDATE_CONTROL, 32'h54);
        pin_chk("allow", 32'h0);
        wr(OFF_ACTIVE_UPDATE_CONTROL, 32'h15);
        pin_chk("allow", 32'h3);
        foreach (upd[i]) wr(OFF_ACTIVE_UPDATE_CONTROL, upd[i]);
        repeat (4) @(posedge i_clk);
        chk("global pulses", 32'h1, n_glob);
        for (int k = 0; k < 3; k++) chk("operator pulses", 32'(3 - k), n_op[k]);
        rc("control", OFF_ACTIVE_UPDATE_CONTROL, 32'h37);
        // ----------------------------------------
        // capture on both edges
        // ----------------------------------------
        wr(OFF_CAPTURE_EDGE_SELECT, 32'h3f);
        for (int n = 0; n < 3; n++) begin
            for (int e = 0; e < 2; e++) begin
                tv = 32'h5a000000 + 32'(n * 16 + e);
                i_timer_value <= tv;
                i_capture_in[n] <= (e == 0);
                repeat (10) @(posedge i_clk);
                rc("value", OFF_CAPTURE_VALUE_CH0 + 12'(4 * n), tv);
                rc("edge", OFF_CAPTURE_EDGE_STATUS, 32'((1 << (n + e)) - 1));
            end
        end
        wr(OFF_CAPTURE_VALUE_CH0, 32'hffffffff);
        rc("value", OFF_CAPTURE_VALUE_CH0, 32'h5a000001);
        wr(OFF_CAPTURE_EDGE_SELECT, 32'h15);
        i_timer_value <= 32'h77;
        i_capture_in[0] <= 1'b1;
        repeat (10) @(posedge i_clk);
        rc("value", OFF_CAPTURE_VALUE_CH0, 32'h5a000001);
        i_timer_value <= 32'h88;
        i_capture_in[0] <= 1'b0;
        repeat (10) @(posedge i_clk);
        rc("value", OFF_CAPTURE_VALUE_CH0, 32'h88);
        // rising edges only
        wr(OFF_CAPTURE_EDGE_SELECT, 32'h2a);
        i_timer_value <= 32'h99;
        i_capture_in[0] <= 1'b1;
        repeat (10) @(posedge i_clk);
        rc("value", OFF_CAPTURE_VALUE_CH0, 32'h99);
        rc("edge", OFF_CAPTURE_EDGE_STATUS, 32'h6);
        for (int k = 0; k < 3; k++) chk("captures", 32'(k == 0 ? 4 : 2), n_cap[k]);
        // ----------------------------------------
        // enable gating
        // ----------------------------------------
        @(posedge i_clk);
        for (int f = 0; f < 7; f++) ev[f] <= 3'h7;
        i_fault_input_event <= 3'h7;
        @(posedge i_clk);
        for (int f = 0; f < 7; f++) ev[f] <= 3'h0;
        i_fault_input_event <= 3'h0;
        rc("raw", OFF_INTERRUPT_RAW, 32'h3fffffff);
        pin_chk("irq", 32'h3);
        for (int i = 0; i < 30; i++) begin
            wr(OFF_INTERRUPT_ENABLE, 32'h1 << i);
            pin_chk("irq", 32'hb);
            rc("masked", OFF_INTERRUPT_MASKED, 32'h1 << i);
        end
        rc("enable", OFF_INTERRUPT_ENABLE, 32'h20000000);
        wr(OFF_INTERRUPT_CLEAR, 32'h3fffffff);
        pin_chk("irq", 32'h3);
        // ----------------------------------------
        // event to flag mapping, one unit at a time
        // ----------------------------------------
        for (int f = 0; f < 9; f++)
            for (int n = 0; n < 3; n++) begin
                @(posedge i_clk);
                if (f < 7) ev[f][n] <= 1'b1;
                else i_fault_input_event[n] <= (f == 7);
                @(posedge i_clk);
                if (f < 7) ev[f][n] <= 1'b0;
                rc("raw", OFF_INTERRUPT_RAW, 32'h1 << (lsb[f] + n));
                wr(OFF_INTERRUPT_CLEAR, 32'h3fffffff);
            end
        end_of_test();
    end
endmodule

bind pwm_capture_update_int_regs pwm_regs_checker #(.TIMER_W(TIMER_W)) chk_i (.i_clk, .i_rst_b, .i_hsel,
    .i_haddr, .i_htrans, .i_hwrite, .i_hready, .o_hreadyout, .i_capture_in, .o_oper_refresh_allow,
    .o_oper_forced_refresh, .o_global_forced_refresh, .o_capture_event, .o_irq);
